// file: verilog/adc_result_output_port_mux.v
// Purpose: Result output port: 16-bit parallel, byte, or dual serial.
// Assumes: cs_n, rd_sclk_n and bus inputs are asynchronous pins; results come from clk logic.
// Notes: Pins are split into input, output and output enable.
`timescale 1ns/1ps
`include "adc_port_regs.vh"

module adc_result_output_port_mux #(
  parameter RES_W = `RES_W
) (
  input wire clk,
  input wire rst_n,
  input wire [RES_W-1:0] result_a,
  input wire [RES_W-1:0] result_b,
  input wire result_valid,
  output reg result_ready,
  input wire interface_kind_select,
  input wire cs_n,
  input wire rd_sclk_n,
  input wire reference_select,
  input wire [RES_W-1:0] parallel_result_bus_in,
  output reg [RES_W-1:0] parallel_result_bus_out,
  output reg [RES_W-1:0] parallel_result_bus_oe,
  output reg internal_ref_enable,
  output reg [1:0] mode_q
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [4:0] pins_s;
  wire cs_n_s;
  wire rd_n_s;
  wire kind_s;
  wire byte_sel_s;
  wire upper_first_s;
  wire ref_s;

  pin_sync #(.W(5), .RST_VAL(5'h1F)) u_sync_strobe (
    .clk(clk),
    .rst_n(rst_n),
    .d({cs_n, rd_sclk_n, parallel_result_bus_in[`PIN_BYTE_SEL],
        parallel_result_bus_in[`PIN_UPPER_FIRST], 1'b1}),
    .q(pins_s)
  );

  pin_sync #(.W(2), .RST_VAL(2'h0)) u_sync_level (
    .clk(clk),
    .rst_n(rst_n),
    .d({interface_kind_select, reference_select}),
    .q({kind_s, ref_s})
  );

  assign cs_n_s = pins_s[4];
  assign rd_n_s = pins_s[3];
  assign byte_sel_s = pins_s[2];
  assign upper_first_s = pins_s[1];

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  wire [2*RES_W-1:0] buf_data;
  wire buf_valid;
  reg buf_pop;
  wire buf_in_ready;

  result_buf2 #(.W(2*RES_W), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_data({result_a, result_b}),
    .in_valid(result_valid),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function [1:0] decode_mode;
    input kind;
    input byte_sel;
    begin
      if (!kind) begin
        decode_mode = `MODE_PAR16;
      end else if (byte_sel) begin
        decode_mode = `MODE_BYTE;
      end else begin
        decode_mode = `MODE_SERIAL;
      end
    end
  endfunction

  wire [1:0] mode_d;
  reg cs_n_q;
  reg rd_n_q;
  wire cs_fall;
  wire cs_rise;
  wire rd_rise;
  wire frame_on;
  reg [RES_W-1:0] sh_a_q;
  reg [RES_W-1:0] sh_b_q;
  reg [RES_W-1:0] word_q;
  reg word_ok_q;
  reg half_q;
  reg first_q;
  reg [1:0] mode_lock_q;

  assign mode_d = decode_mode(kind_s, byte_sel_s);
  assign cs_fall = cs_n_q && !cs_n_s;
  assign cs_rise = !cs_n_q && cs_n_s;
  assign rd_rise = !rd_n_q && rd_n_s;
  assign frame_on = !cs_n_s;

  // ----------------------------------------
  // Read sequencing
  // ----------------------------------------
  // Mode is latched when idle so it stays fixed through a frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      mode_lock_q <= `MODE_PAR16;
      mode_q <= `MODE_PAR16;
      internal_ref_enable <= 1'b0;
      result_ready <= 1'b0;
      sh_a_q <= `RES_RST;
      sh_b_q <= `RES_RST;
      word_q <= `RES_RST;
      word_ok_q <= 1'b0;
      half_q <= 1'b0;
      first_q <= 1'b0;
      buf_pop <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      rd_n_q <= rd_n_s;
      internal_ref_enable <= ref_s;
      result_ready <= buf_in_ready;
      buf_pop <= 1'b0;
      if (cs_n_s && !cs_fall) begin
        mode_lock_q <= mode_d;
      end
      mode_q <= mode_lock_q;
      if (!word_ok_q && buf_valid && !buf_pop && cs_n_s) begin
        word_q <= buf_data[2*RES_W-1:RES_W];
        sh_b_q <= buf_data[RES_W-1:0];
        word_ok_q <= 1'b1;
        half_q <= 1'b0;
        buf_pop <= 1'b1;
      end
      case (mode_lock_q)
        `MODE_SERIAL: begin
          if (cs_fall) begin
            sh_a_q <= word_q;
            first_q <= 1'b1;
          end else if (frame_on && rd_rise) begin
            sh_a_q <= {sh_a_q[RES_W-2:0], 1'b0};
            sh_b_q <= {sh_b_q[RES_W-2:0], 1'b0};
          end
          if (cs_rise && first_q) begin
            word_ok_q <= 1'b0;
            first_q <= 1'b0;
          end
        end
        `MODE_BYTE: begin
          if (frame_on && rd_rise) begin
            half_q <= !half_q;
            if (half_q) begin
              word_ok_q <= 1'b0;
            end
          end
        end
        `MODE_PAR16: begin
          if (frame_on && rd_rise) begin
            word_ok_q <= 1'b0;
          end
        end
        default: begin
          half_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire read_on;
  wire [`BYTE_W-1:0] byte_now;

  assign read_on = !cs_n_s && !rd_n_s;
  // Upper first picks the high byte on the first read
  assign byte_now = (upper_first_s ^ half_q) ? word_q[RES_W-1:`BYTE_W]
    : word_q[`BYTE_W-1:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parallel_result_bus_out <= `RES_RST;
      parallel_result_bus_oe <= `RES_RST;
    end else begin
      parallel_result_bus_out <= `RES_RST;
      parallel_result_bus_oe <= `RES_RST;
      case (mode_lock_q)
        `MODE_PAR16: begin
          if (read_on) begin
            parallel_result_bus_out <= word_q;
            parallel_result_bus_oe <= {RES_W{1'b1}};
          end
        end
        `MODE_BYTE: begin
          if (read_on) begin
            parallel_result_bus_out[`BYTE_W-1:0] <= byte_now;
            parallel_result_bus_oe[`BYTE_W-1:0] <= {`BYTE_W{1'b1}};
          end
        end
        `MODE_SERIAL: begin
          if (frame_on) begin
            parallel_result_bus_out[`PIN_SER_FIRST] <= cs_fall ? word_q[RES_W-1]
              : sh_a_q[RES_W-1];
            parallel_result_bus_out[`PIN_SER_SECOND] <= sh_b_q[RES_W-1];
            parallel_result_bus_oe[`PIN_SER_FIRST] <= 1'b1;
            parallel_result_bus_oe[`PIN_SER_SECOND] <= 1'b1;
          end
        end
        default: begin
          parallel_result_bus_oe <= `RES_RST;
        end
      endcase
    end
  end

endmodule // adc_result_output_port_mux

// file: verilog/adc_port_regs.vh
// Purpose: Constants for the result output port.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH

// ----------------------------------------
// Widths and pin positions
// ----------------------------------------
`define RES_W 16
`define BYTE_W 8
`define PIN_BYTE_SEL 15
`define PIN_UPPER_FIRST 14
`define PIN_SER_SECOND 8
`define PIN_SER_FIRST 7

// ----------------------------------------
// Interface modes
// ----------------------------------------
`define MODE_PAR16 2'h0
`define MODE_BYTE 2'h1
`define MODE_SERIAL 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RES_RST 16'h0000

`endif

// file: verilog/pin_sync.v
// Purpose: Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps

module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // pin_sync

// file: verilog/result_buf2.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock.
// Notes: Full and empty are exact; no word is lost under stall.
`timescale 1ns/1ps

module result_buf2 #(
  parameter W = 16,
  parameter DEPTH = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [1:0] wr_q;
  reg [1:0] rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[1:0]);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem[rd_q[0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q[0]] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 2'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 2'h1;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // result_buf2

// file: verification/adc_port_monitor.sv
// Purpose: Port checker for the result port.
// Assumes: Bound to the top module.
// Notes: Pin effects land 3 clk late; mode_q lands 4 clk late.
`timescale 1ns/1ps
module adc_port_monitor #(parameter RES_W = 16) (
  input wire clk,
  input wire rst_n,
  input wire cs_n,
  input wire rd_sclk_n,
  input wire interface_kind_select,
  input wire reference_select,
  input wire [RES_W-1:0] parallel_result_bus_in,
  input wire [RES_W-1:0] parallel_result_bus_oe,
  input wire internal_ref_enable,
  input wire [1:0] mode_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  cs_release_a: assert property (cs_n [*4] |-> parallel_result_bus_oe == 16'h0000)
    else $error("bus driven with cs high");
  rd_release_a: assert property ((mode_q != 2'h2 && rd_sclk_n) [*4]
    |-> parallel_result_bus_oe == 16'h0000) else $error("bus driven with rd high");
  full_word_a: assert property (mode_q == 2'h0 && parallel_result_bus_oe != 16'h0000
    |-> parallel_result_bus_oe == 16'hFFFF) else $error("partial word");
  byte_pins_a: assert property (mode_q == 2'h1
    |-> parallel_result_bus_oe[15:8] == 8'h00) else $error("upper pins driven");
  serial_pins_a: assert property (mode_q == 2'h2
    |-> (parallel_result_bus_oe & 16'hFE7F) == 16'h0000) else $error("wrong serial pins");
  ref_follow_a: assert property ($stable(reference_select) [*5]
    |-> internal_ref_enable == reference_select) else $error("reference enable");
  mode_byte_a: assert property ((interface_kind_select && parallel_result_bus_in[15]
    && cs_n) [*5] |-> mode_q == 2'h1) else $error("byte mode");
  serial_start_a: assert property (mode_q == 2'h2 && $fell(cs_n)
    |-> ##[2:4] (parallel_result_bus_oe[7] && parallel_result_bus_oe[8]))
    else $error("serial outputs late");
endmodule // adc_port_monitor
bind adc_result_output_port_mux adc_port_monitor #(.RES_W(RES_W)) mon (.clk(clk),
  .rst_n(rst_n), .cs_n(cs_n), .rd_sclk_n(rd_sclk_n),
  .interface_kind_select(interface_kind_select), .reference_select(reference_select),
  .parallel_result_bus_in(parallel_result_bus_in),
  .parallel_result_bus_oe(parallel_result_bus_oe),
  .internal_ref_enable(internal_ref_enable), .mode_q(mode_q));

// file: verification/host_reader.sv
// Purpose: Host model that reads results.
// Assumes: Undriven lines sit at ground, except the strap bits 15 and 14 when kind is set.
// Notes: Strobes last 6 clk; serial clock 80 ns.
`timescale 1ns/1ps
module host_reader (
  input wire [15:0] bus_out,
  input wire [15:0] bus_oe,
  input wire kind,
  input wire byte_sel,
  input wire upper_half_first,
  output reg cs_n,
  output reg rd_sclk_n,
  output wire [15:0] bus_in
);
  wire [15:0] strap = kind ? {byte_sel, upper_half_first, 14'h0000} : 16'h0000;
  assign bus_in = (bus_out & bus_oe) | (strap & ~bus_oe);
  initial begin
    cs_n = 1'b1;
    rd_sclk_n = 1'b1;
  end
  task par_read(input integer n, output [15:0] w);
    integer i;
    begin
      w = 16'h0000;
      cs_n = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        rd_sclk_n = 1'b0;
        #48 w = (n == 1) ? bus_in : {w[7:0], bus_in[7:0]};
        rd_sclk_n = 1'b1;
        #48;
      end
      cs_n = 1'b1;
      #48;
    end
  endtask
  task ser_read(output [15:0] a, output [15:0] b);
    integer i;
    begin
      cs_n = 1'b0;
      #40;
      for (i = 0; i < 16; i = i + 1) begin
        rd_sclk_n = 1'b0;
        #40 a = {a[14:0], bus_in[7]};
        b = {b[14:0], bus_in[8]};
        rd_sclk_n = 1'b1;
        #40;
      end
      cs_n = 1'b1;
      #48;
    end
  endtask
endmodule // host_reader

// file: verification/testbench.sv
// Purpose: Self-checking bench for the result port.
// Assumes: Host model drives strobes and straps.
// Notes: Rows cover each mode; fill and reset follow.
`timescale 1ns/1ps
module testbench;
  reg clk, rst_n, result_valid, kind, byte_sel, hbf, ref_sel;
  reg [15:0] res_a, res_b, got_a, got_b;
  wire [15:0] bus_in, bus_out, bus_oe;
  wire result_ready, cs_n, rd_sclk_n, ref_en;
  wire [1:0] mode_q;
  reg [68:0] rows [0:3];
  integer num_errors = 0, checks = 0, cycles = 0, i;
  adc_result_output_port_mux DUT (.clk(clk), .rst_n(rst_n), .result_a(res_a),
    .result_b(res_b), .result_valid(result_valid), .result_ready(result_ready),
    .interface_kind_select(kind), .cs_n(cs_n), .rd_sclk_n(rd_sclk_n),
    .reference_select(ref_sel), .parallel_result_bus_in(bus_in),
    .parallel_result_bus_out(bus_out), .parallel_result_bus_oe(bus_oe),
    .internal_ref_enable(ref_en), .mode_q(mode_q));
  host_reader host (.bus_out(bus_out), .bus_oe(bus_oe), .kind(kind), .byte_sel(byte_sel),
    .upper_half_first(hbf), .cs_n(cs_n), .rd_sclk_n(rd_sclk_n), .bus_in(bus_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task check(input [8*6-1:0] name, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task push(input [15:0] a, input [15:0] b);
    begin
      res_a = a;
      res_b = b;
      result_valid = 1'b1;
      @(posedge clk);
      while (result_ready !== 1'b1) @(posedge clk);
      #1 result_valid = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    rst_n = 1'b0;
    result_valid = 1'b0;
    {kind, byte_sel, hbf, ref_sel} = 4'h1;
    res_a = 16'h0000;
    res_b = 16'h0000;
    rows[0] = {5'b00000, 16'hA5C3, 16'h1234, 16'hA5C3, 16'h0000};
    rows[1] = {5'b11101, 16'h8E71, 16'h0000, 16'h8E71, 16'h0000};
    rows[2] = {5'b11001, 16'h3CF0, 16'h0000, 16'hF03C, 16'h0000};
    rows[3] = {5'b10010, 16'hC3A5, 16'h5A0F, 16'hC3A5, 16'h5A0F};
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      {kind, byte_sel, hbf} = rows[i][68:66];
      repeat (6) @(posedge clk);
      #1 push(rows[i][63:48], rows[i][47:32]);
      check("mode", {14'h0000, mode_q}, {14'h0000, rows[i][65:64]});
      got_b = 16'h0000;
      if (rows[i][65:64] == 2'h2) host.ser_read(got_a, got_b);
      else host.par_read(rows[i][64] ? 2 : 1, got_a);
      check("word_a", got_a, rows[i][31:16]);
      check("word_b", got_b, rows[i][15:0]);
    end
    check("ref_on", {15'h0000, ref_en}, 16'h0001);
    kind = 1'b0;
    for (i = 1; i < 4; i = i + 1) push(16'h1111 * i[15:0], 16'h0000);
    check("full", {15'h0000, result_ready}, 16'h0000);
    for (i = 1; i < 4; i = i + 1) begin
      host.par_read(1, got_a);
      check("drain", got_a, 16'h1111 * i[15:0]);
    end
    rst_n = 1'b0;
    #16 check("rst_oe", bus_oe, 16'h0000);
    check("rst_md", {14'h0000, mode_q}, 16'h0000);
    rst_n = 1'b1;
    ref_sel = 1'b0;
    #48 check("ref", {15'h0000, ref_en}, 16'h0000);
    finish_test;
  end
endmodule // testbench
